// ### logic/mem_pkg.sv
// Purpose: Shared constants, modes and helpers for the memory block and its fabric end.
// Assumes: One ref_clk; each clock domain of the block is an enable on that clock.
// Notes: Default geometry is 256 words of 36 bits, one full block.
package mem_pkg;

  localparam int DATA_W = 36;
  localparam int ADDR_W = 8;
  localparam int BLOCK_BITS = 9216;
  localparam int MAX_PORT_W = 36;
  localparam int SR_LEN = 16;
  localparam int SR_TAPS = 2;
  localparam logic [35:0] ROM_SEED = 36'h0_0000_0001;
  localparam logic [35:0] ROM_STEP = 36'h0_0101_0103;
  localparam logic RST_FLAG_LOW = 1'b0;
  localparam logic RST_FLAG_HIGH = 1'b1;

  typedef enum logic [2:0] {
    ram_sp = 3'h0,
    ram_sdp = 3'h1,
    ram_tdp = 3'h3,
    rom_sp = 3'h2,
    rom_dp = 3'h6,
    shift_reg = 3'h7,
    one_clock_queue = 3'h5,
    two_clock_queue = 3'h4
  } mem_mode_type;

  typedef enum logic [1:0] {
    clk_single = 2'h0,
    clk_in_out = 2'h1,
    clk_rd_wr = 2'h3,
    clk_indep = 2'h2
  } clk_mode_type;

  // Tells whether a memory mode may run in a clock mode.
  function automatic logic mode_allowed(input mem_mode_type m, input clk_mode_type c);
    logic ok;
    ok = 1'b0;
    unique case (c)
      clk_single: ok = (m != two_clock_queue);
      clk_indep: ok = (m == ram_tdp) || (m == rom_sp) || (m == rom_dp);
      clk_in_out: ok = (m == ram_sp) || (m == ram_sdp) || (m == ram_tdp)
                    || (m == rom_sp) || (m == rom_dp);
      clk_rd_wr: ok = (m == ram_sdp) || (m == two_clock_queue);
    endcase
    return ok;
  endfunction

  // Fixed ROM pattern for word i.
  function automatic logic [35:0] rom_word(input int i);
    return ROM_SEED + 36'(i) * ROM_STEP;
  endfunction

endpackage

// ### logic/mem_link.sv
// Purpose: Port bundle between the memory block and the fabric logic that drives it.
// Assumes: Both ends run on the same ref_clk.
// Notes: Port A is the write or input side, port B the read or second side.
`timescale 1ns/1ps
interface mem_link #(
  parameter int DATA_W = mem_pkg::DATA_W,
  parameter int ADDR_W = mem_pkg::ADDR_W
);
  logic ce_a;
  logic ce_b;
  logic clr_a;
  logic clr_b;
  logic [ADDR_W-1:0] a_addr;
  logic [DATA_W-1:0] a_wdata;
  logic a_wren;
  logic a_rden;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_wdata;
  logic b_wren;
  logic b_rden;
  logic [DATA_W-1:0] q_a;
  logic [DATA_W-1:0] q_b;
  logic full;
  logic empty;
  logic cfg_err;

  modport dev (
    input ce_a, ce_b, clr_a, clr_b, a_addr, a_wdata, a_wren, a_rden,
    input b_addr, b_wdata, b_wren, b_rden,
    output q_a, q_b, full, empty, cfg_err
  );

  modport fab (
    output ce_a, ce_b, clr_a, clr_b, a_addr, a_wdata, a_wren, a_rden,
    output b_addr, b_wdata, b_wren, b_rden,
    input q_a, q_b, full, empty, cfg_err
  );
endinterface

// ### logic/mem_block.sv
// Purpose: Synchronous memory block usable as RAM, ROM, shift register or queue.
// Assumes: Clock domains are modelled as enables ce_a and ce_b on ref_clk.
// Notes: Memory contents are not reset; ROM words come from a fixed pattern.
`timescale 1ns/1ps
module mem_block #(
  parameter int DATA_W = mem_pkg::DATA_W,
  parameter int ADDR_W = mem_pkg::ADDR_W,
  parameter mem_pkg::mem_mode_type MEM_MODE = mem_pkg::ram_tdp,
  parameter mem_pkg::clk_mode_type CLK_MODE = mem_pkg::clk_single,
  parameter bit OUT_REG = 1'b1,
  parameter int SR_LEN = mem_pkg::SR_LEN,
  parameter int SR_TAPS = mem_pkg::SR_TAPS
)(
  input wire logic ref_clk,
  input wire logic nrst,
  mem_link.dev lnk
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int SR_W = DATA_W / SR_TAPS;
  localparam logic CFG_OK = mem_pkg::mode_allowed(MEM_MODE, CLK_MODE);
  localparam logic IS_ROM = (MEM_MODE == mem_pkg::rom_sp) || (MEM_MODE == mem_pkg::rom_dp);
  localparam logic IS_QUEUE = (MEM_MODE == mem_pkg::one_clock_queue)
                           || (MEM_MODE == mem_pkg::two_clock_queue);
  localparam logic IS_SR = (MEM_MODE == mem_pkg::shift_reg);
  localparam logic B_READS = (MEM_MODE == mem_pkg::ram_sdp) || (MEM_MODE == mem_pkg::ram_tdp)
                          || (MEM_MODE == mem_pkg::rom_dp);

  logic [DATA_W-1:0] mem [DEPTH];
  logic a_in_en, b_in_en, a_out_en, b_out_en;
  logic a_we, a_re, b_we, b_re;
  logic [ADDR_W-1:0] a_waddr, a_raddr, b_raddr;
  logic [DATA_W-1:0] a_wdat;
  logic a_clr_n, b_clr_n;
  logic push, pop;
  logic [ADDR_W-1:0] wr_ptr_r, rd_ptr_r;
  logic [ADDR_W:0] cnt_r, cnt_nxt;
  logic full_r, empty_r;
  logic [ADDR_W-1:0] sr_ptr_r;
  logic [DATA_W-1:0] a_raw_r, b_raw_r;
  logic [DATA_W-1:0] a_out_r, b_out_r;
  logic cfg_err_r;

  // Fixed ROM pattern; writes are refused in ROM modes.
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem[i] = DATA_W'(mem_pkg::rom_word(i));
    end
  end

  // Maps the two user clock enables onto the domains of the chosen clock mode.
  always_comb
  begin
    a_in_en = lnk.ce_a & CFG_OK;
    b_in_en = 1'b0;
    a_out_en = 1'b0;
    b_out_en = 1'b0;
    unique case (CLK_MODE)
      mem_pkg::clk_single:
      begin
        b_in_en = lnk.ce_a;
        a_out_en = lnk.ce_a;
        b_out_en = lnk.ce_a;
      end
      mem_pkg::clk_indep:
      begin
        b_in_en = lnk.ce_b;
        a_out_en = lnk.ce_a;
        b_out_en = lnk.ce_b;
      end
      mem_pkg::clk_in_out:
      begin
        b_in_en = lnk.ce_a;
        a_out_en = lnk.ce_b;
        b_out_en = lnk.ce_b;
      end
      mem_pkg::clk_rd_wr:
      begin
        b_in_en = lnk.ce_b;
        b_out_en = lnk.ce_b;
      end
    endcase
    b_in_en = b_in_en & CFG_OK;
    a_out_en = a_out_en & CFG_OK;
    b_out_en = b_out_en & CFG_OK;
  end

  // Queue handshakes; a pop on an empty queue is dropped.
  always_comb
  begin
    push = IS_QUEUE && a_in_en && lnk.a_wren && !full_r;
    pop = IS_QUEUE && b_in_en && lnk.b_rden && !empty_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Port strobes and addresses per memory mode.
  always_comb
  begin
    a_waddr = lnk.a_addr;
    a_wdat = lnk.a_wdata;
    a_raddr = lnk.a_addr;
    b_raddr = lnk.b_addr;
    a_we = a_in_en && lnk.a_wren && !IS_ROM && (MEM_MODE != mem_pkg::ram_sdp || 1'b1);
    a_re = a_in_en && lnk.a_rden && !IS_QUEUE && (MEM_MODE != mem_pkg::ram_sdp);
    b_we = b_in_en && lnk.b_wren && (MEM_MODE == mem_pkg::ram_tdp);
    b_re = b_in_en && lnk.b_rden && B_READS;
    if (IS_QUEUE)
    begin
      a_we = push;
      a_waddr = wr_ptr_r;
      b_re = pop;
      b_raddr = rd_ptr_r;
    end
    else if (IS_SR)
    begin
      // Each word holds all taps; the word read back is the one written SR_LEN shifts ago.
      a_we = a_in_en && lnk.a_wren;
      a_re = a_we;
      a_waddr = sr_ptr_r;
      a_raddr = sr_ptr_r;
      a_wdat = DATA_W'(mem[sr_ptr_r] << SR_W) | DATA_W'(lnk.a_wdata[SR_W-1:0]);
    end
  end

  // Array writes from both ports.
  always_ff @(posedge ref_clk)
  begin
    if (a_we)
    begin
      mem[a_waddr] <= a_wdat;
    end
    if (b_we)
    begin
      mem[lnk.b_addr] <= lnk.b_wdata;
    end
  end

  // Queue pointers and level flags.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      full_r <= mem_pkg::RST_FLAG_LOW;
      empty_r <= mem_pkg::RST_FLAG_HIGH;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == (ADDR_W+1)'(DEPTH));
      empty_r <= IS_QUEUE && (cnt_nxt == '0);
    end
  end

  // Shift register write pointer wraps after SR_LEN words.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sr_ptr_r <= '0;
    end
    else if (IS_SR && a_we)
    begin
      sr_ptr_r <= (sr_ptr_r == ADDR_W'(SR_LEN - 1)) ? '0 : sr_ptr_r + 1'b1;
    end
  end

  // User clears reach only the read data registers.
  assign a_clr_n = nrst & ~lnk.clr_a;
  assign b_clr_n = nrst & ~lnk.clr_b;

  // Address is captured with the read on the input edge; old data wins a same-address write.
  // The optional output stage follows on the output domain enable.
  always_ff @(posedge ref_clk or negedge a_clr_n)
  begin
    if (!a_clr_n)
    begin
      a_raw_r <= '0;
      a_out_r <= '0;
    end
    else
    begin
      if (a_re)
      begin
        a_raw_r <= mem[a_raddr];
      end
      if (a_out_en)
      begin
        a_out_r <= a_raw_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge b_clr_n)
  begin
    if (!b_clr_n)
    begin
      b_raw_r <= '0;
      b_out_r <= '0;
    end
    else
    begin
      if (b_re)
      begin
        b_raw_r <= mem[b_raddr];
      end
      if (b_out_en)
      begin
        b_out_r <= b_raw_r;
      end
    end
  end

  // Flags an illegal pairing of memory mode and clock mode.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_err_r <= mem_pkg::RST_FLAG_LOW;
    end
    else
    begin
      cfg_err_r <= !CFG_OK;
    end
  end

  assign lnk.q_a = OUT_REG ? a_out_r : a_raw_r;
  assign lnk.q_b = OUT_REG ? b_out_r : b_raw_r;
  assign lnk.full = full_r;
  assign lnk.empty = empty_r;
  assign lnk.cfg_err = cfg_err_r;

endmodule

// ### logic/fabric_end.sv
// Purpose: Fabric side that registers user requests onto the memory ports.
// Assumes: Same ref_clk as the memory block.
// Notes: Drops a pop that would meet a push on an empty queue.
`timescale 1ns/1ps
module fabric_end #(
  parameter int DATA_W = mem_pkg::DATA_W,
  parameter int ADDR_W = mem_pkg::ADDR_W,
  parameter int SR_W = mem_pkg::DATA_W / mem_pkg::SR_TAPS,
  parameter int SR_LEN = mem_pkg::SR_LEN,
  parameter int SR_TAPS = mem_pkg::SR_TAPS
)(
  input wire logic ref_clk,
  input wire logic nrst,
  mem_link.fab lnk,
  input wire logic u_ce_a,
  input wire logic u_ce_b,
  input wire logic u_clr_a,
  input wire logic u_clr_b,
  input wire logic [ADDR_W-1:0] u_a_addr,
  input wire logic [DATA_W-1:0] u_a_wdata,
  input wire logic u_a_wren,
  input wire logic u_a_rden,
  input wire logic [ADDR_W-1:0] u_b_addr,
  input wire logic [DATA_W-1:0] u_b_wdata,
  input wire logic u_b_wren,
  input wire logic u_b_rden,
  output logic [DATA_W-1:0] u_q_a,
  output logic [DATA_W-1:0] u_q_b,
  output logic u_full,
  output logic u_empty,
  output logic u_cfg_err,
  output logic u_refused
);

  localparam logic SIZE_OK = (SR_W * SR_LEN * SR_TAPS <= mem_pkg::BLOCK_BITS)
                          && (SR_W * SR_TAPS <= mem_pkg::MAX_PORT_W);

  logic clash;
  logic ce_a_r;
  logic ce_b_r;
  logic clr_a_r;
  logic clr_b_r;
  logic [ADDR_W-1:0] a_addr_r;
  logic [DATA_W-1:0] a_wdata_r;
  logic a_wren_r;
  logic a_rden_r;
  logic [ADDR_W-1:0] b_addr_r;
  logic [DATA_W-1:0] b_wdata_r;
  logic b_wren_r;
  logic b_rden_r;

  // A push and a pop aimed at an empty queue would collide; the pop is withheld.
  assign clash = lnk.empty && u_a_wren && u_b_rden;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ce_a_r <= 1'b0;
      ce_b_r <= 1'b0;
      clr_a_r <= 1'b0;
      clr_b_r <= 1'b0;
      a_addr_r <= '0;
      a_wdata_r <= '0;
      a_wren_r <= 1'b0;
      a_rden_r <= 1'b0;
      b_addr_r <= '0;
      b_wdata_r <= '0;
      b_wren_r <= 1'b0;
      b_rden_r <= 1'b0;
      u_refused <= 1'b0;
    end
    else
    begin
      ce_a_r <= u_ce_a;
      ce_b_r <= u_ce_b;
      clr_a_r <= u_clr_a;
      clr_b_r <= u_clr_b;
      a_addr_r <= u_a_addr;
      a_wdata_r <= u_a_wdata;
      a_wren_r <= u_a_wren;
      a_rden_r <= u_a_rden;
      b_addr_r <= u_b_addr;
      b_wdata_r <= u_b_wdata;
      b_wren_r <= u_b_wren;
      b_rden_r <= u_b_rden && !clash;
      u_refused <= clash;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      u_q_a <= '0;
      u_q_b <= '0;
      u_full <= 1'b0;
      u_empty <= 1'b1;
      u_cfg_err <= 1'b0;
    end
    else
    begin
      u_q_a <= lnk.q_a;
      u_q_b <= lnk.q_b;
      u_full <= lnk.full;
      u_empty <= lnk.empty;
      u_cfg_err <= lnk.cfg_err || !SIZE_OK;
    end
  end

  assign lnk.ce_a = ce_a_r;
  assign lnk.ce_b = ce_b_r;
  assign lnk.clr_a = clr_a_r;
  assign lnk.clr_b = clr_b_r;
  assign lnk.a_addr = a_addr_r;
  assign lnk.a_wdata = a_wdata_r;
  assign lnk.a_wren = a_wren_r;
  assign lnk.a_rden = a_rden_r;
  assign lnk.b_addr = b_addr_r;
  assign lnk.b_wdata = b_wdata_r;
  assign lnk.b_wren = b_wren_r;
  assign lnk.b_rden = b_rden_r;

endmodule

// ### bench/block_ram_clock_modes_checker.sv
// Purpose: Port-level checks on the link between the memory block and the fabric end.
// Assumes: True dual-port RAM, single clock mode, output register in use.
// Notes: Every domain is an enable on ref_clk, so one default clocking serves.
`timescale 1ns/1ps
module block_ram_clock_modes_checker #(
  parameter int DATA_W = mem_pkg::DATA_W,
  parameter int ADDR_W = mem_pkg::ADDR_W
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce_a,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic a_wren,
  input wire logic a_rden,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic b_wren,
  input wire logic b_rden,
  input wire logic [DATA_W-1:0] q_a,
  input wire logic [DATA_W-1:0] q_b,
  input wire logic cfg_err
);
  logic rd_a;
  logic rd_b;
  assign rd_a = ce_a && a_rden;
  assign rd_b = ce_a && b_rden;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_CLR_A: assert property (clr_a |-> q_a == '0)
    else $error("q_a not cleared");
  AST_CLR_B: assert property (clr_b |-> q_b == '0)
    else $error("q_b not cleared");
  AST_QA_CAUSE: assert property (!$stable(q_a) && $past(q_a) != '0 && !clr_a |-> $past(rd_a, 2))
    else $error("q_a changed without a read two cycles before");
  AST_QB_CAUSE: assert property (!$stable(q_b) && $past(q_b) != '0 && !clr_b |-> $past(rd_b, 2))
    else $error("q_b changed without a read two cycles before");
  AST_CE_HOLD_A: assert property (!ce_a ##1 !clr_a |-> $stable(q_a))
    else $error("q_a moved with the clock enable low");
  AST_CE_HOLD_B: assert property (!ce_a ##1 !clr_b |-> $stable(q_b))
    else $error("q_b moved with the clock enable low");
  AST_SAME_ADDR: assert property (rd_a && rd_b && a_addr == b_addr && !a_wren && !b_wren
    ##1 ce_a && !clr_a && !clr_b |=> q_a == q_b)
    else $error("both ports read one address but disagree");
  AST_NO_CFG_ERR: assert property (!cfg_err)
    else $error("legal mode pair flagged as illegal");
  cover property (rd_a && rd_b && a_addr == b_addr);
  cover property (clr_a && q_b != '0);
  cover property (!ce_a && $past(rd_a));
endmodule

// ### bench/test_block_ram_clock_modes.sv
// Purpose: Drives the fabric end against the memory block and scores all read data.
// Assumes: True dual-port RAM, single clock mode, four cycles from request to user data.
// Notes: The model returns old data when a read meets a write to the same word.
`timescale 1ns/1ps
module test_block_ram_clock_modes;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic u_ce_a = 1'b0, u_ce_b = 1'b0, u_clr_a = 1'b0, u_clr_b = 1'b0;
  logic u_a_wren = 1'b0, u_a_rden = 1'b0, u_b_wren = 1'b0, u_b_rden = 1'b0;
  logic [7:0] u_a_addr = 8'h00, u_b_addr = 8'h00;
  logic [35:0] u_a_wdata = 36'h0, u_b_wdata = 36'h0;
  logic [35:0] u_q_a, u_q_b;
  logic u_full, u_empty, u_cfg_err, u_refused;
  logic [35:0] mem_m [256];
  logic [35:0] exp_a [$];
  logic [35:0] exp_b [$];
  logic [3:0] pa = 4'h0, pb = 4'h0;
  logic prev_rd = 1'b0;
  logic ref_seen = 1'b0;
  int err_total = 0;
  int checked = 0;
  always #2 ref_clk = ~ref_clk;
  mem_link lnk ();
  mem_block #(.MEM_MODE(mem_pkg::ram_tdp), .CLK_MODE(mem_pkg::clk_single), .OUT_REG(1'b1))
    mem_block_i (.ref_clk(ref_clk), .nrst(nrst), .lnk(lnk));
  fabric_end fabric_end_i (.ref_clk(ref_clk), .nrst(nrst), .lnk(lnk), .u_ce_a(u_ce_a),
    .u_ce_b(u_ce_b), .u_clr_a(u_clr_a), .u_clr_b(u_clr_b), .u_a_addr(u_a_addr),
    .u_a_wdata(u_a_wdata), .u_a_wren(u_a_wren), .u_a_rden(u_a_rden), .u_b_addr(u_b_addr),
    .u_b_wdata(u_b_wdata), .u_b_wren(u_b_wren), .u_b_rden(u_b_rden), .u_q_a(u_q_a),
    .u_q_b(u_q_b), .u_full(u_full), .u_empty(u_empty), .u_cfg_err(u_cfg_err),
    .u_refused(u_refused));
  block_ram_clock_modes_checker checker_i (.ref_clk(ref_clk), .nrst(nrst), .ce_a(lnk.ce_a),
    .clr_a(lnk.clr_a), .clr_b(lnk.clr_b), .a_addr(lnk.a_addr), .a_wren(lnk.a_wren),
    .a_rden(lnk.a_rden), .b_addr(lnk.b_addr), .b_wren(lnk.b_wren), .b_rden(lnk.b_rden),
    .q_a(lnk.q_a), .q_b(lnk.q_b), .cfg_err(lnk.cfg_err));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 16; k++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction

  task automatic cmp_data(input string what, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Op bits: 3 port A write, 2 port A read, 1 port B write, 0 port B read.
  task automatic drive_op(input logic ce, input logic [3:0] op, input logic [7:0] aa,
    input logic [7:0] ab, input logic [35:0] da, input logic [35:0] db);
    @(posedge ref_clk);
    ce = ce | prev_rd;
    prev_rd = ce & (op[2] | op[0]);
    u_ce_a <= ce;
    u_ce_b <= ~ce;
    u_a_wren <= op[3];
    u_a_rden <= op[2];
    u_b_wren <= op[1];
    u_b_rden <= op[0];
    u_a_addr <= aa;
    u_b_addr <= ab;
    u_a_wdata <= da;
    u_b_wdata <= db;
    if (ce)
    begin
      if (op[2])
        exp_a.push_back(mem_m[aa]);
      if (op[0])
        exp_b.push_back(mem_m[ab]);
      if (op[3])
        mem_m[aa] = da;
      if (op[1])
        mem_m[ab] = db;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) drive_op(1'b1, 4'h0, 8'h00, 8'h00, 36'h0, 36'h0);
  endtask

  always @(negedge ref_clk)
  begin
    pa <= {pa[2:0], u_ce_a & u_a_rden};
    pb <= {pb[2:0], u_ce_a & u_b_rden};
    ref_seen <= ref_seen | (u_refused !== 1'b0);
    if (pa[3] === 1'b1 && exp_a.size() > 0)
      cmp_data("u_q_a", exp_a.pop_front(), u_q_a);
    if (pb[3] === 1'b1 && exp_b.size() > 0)
      cmp_data("u_q_b", exp_b.pop_front(), u_q_b);
  end

  initial
  begin
    #20000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] r;
    logic [7:0] ab;
    for (int i = 0; i < 256; i++)
      mem_m[i] = mem_pkg::ROM_SEED + 36'(i) * mem_pkg::ROM_STEP;
    r = 32'h6e4d8215;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(2);
    @(negedge ref_clk);
    cmp_bit("u_cfg_err", 1'b0, u_cfg_err);
    cmp_bit("u_empty", 1'b0, u_empty);
    cmp_bit("u_full", 1'b0, u_full);
    cmp_data("u_q_a", 36'h0, u_q_a);
    drive_op(1'b1, 4'h5, 8'hff, 8'hff, 36'h0, 36'h0);
    drive_op(1'b1, 4'ha, 8'h01, 8'h02, 36'h1_2345_6789, 36'hf_edcb_a987);
    drive_op(1'b1, 4'h5, 8'h02, 8'h01, 36'h0, 36'h0);
    drive_op(1'b1, 4'hc, 8'h01, 8'h00, 36'h5_5555_aaaa, 36'h0);
    drive_op(1'b1, 4'h4, 8'h01, 8'h00, 36'h0, 36'h0);
    for (int i = 0; i < 300; i++)
    begin
      r = lfsr(r);
      ab = {4'h0, r[11:8]};
      if (r[3] && r[1] && ab[3:0] == r[7:4])
        ab[0] = ~ab[0];
      drive_op(r[12] | r[13], r[3:0], {4'h0, r[7:4]}, ab, {r[31:28], r}, {r[3:0], ~r});
    end
    drive_op(1'b1, 4'h5, 8'h03, 8'h07, 36'h0, 36'h0);
    idle(5);
    u_clr_a <= 1'b1;
    idle(1);
    u_clr_a <= 1'b0;
    idle(3);
    @(negedge ref_clk);
    cmp_data("u_q_a", 36'h0, u_q_a);
    cmp_data("u_q_b", mem_m[7], u_q_b);
    @(posedge ref_clk);
    u_clr_b <= 1'b1;
    idle(1);
    u_clr_b <= 1'b0;
    idle(3);
    @(negedge ref_clk);
    cmp_data("u_q_b", 36'h0, u_q_b);
    @(posedge ref_clk);
    nrst <= 1'b0;
    idle(3);
    @(negedge ref_clk);
    cmp_data("u_q_b", 36'h0, u_q_b);
    @(posedge ref_clk);
    nrst <= 1'b1;
    idle(2);
    drive_op(1'b1, 4'h5, 8'h01, 8'h02, 36'h0, 36'h0);
    idle(6);
    cmp_bit("u_refused", 1'b0, ref_seen);
    cmp_bit("notes drained", 1'b1, exp_a.size() == 0 && exp_b.size() == 0);
    tally_and_finish();
  end
endmodule
